// ==== hw/mmt_cfg.svh ====
`ifndef MMT_CFG_SVH
`define MMT_CFG_SVH

// register byte offsets on the bus
`define MMT_OFS_CTRL       8'h00
`define MMT_OFS_MANUAL     8'h04
`define MMT_OFS_SCALE      8'h08
`define MMT_OFS_STATUS     8'h0c
`define MMT_OFS_SETPOINT   8'h10
`define MMT_OFS_PROCESS    8'h14
`define MMT_OFS_IRQ_STAT   8'h18
`define MMT_OFS_IRQ_MASK   8'h1c

// control register command bits (write one to act)
`define MMT_CTRL_ENTER     0
`define MMT_CTRL_EXIT      1
`define MMT_CTRL_RESTORE   2
`define MMT_CTRL_COMMIT    3

// scale download register fields
`define MMT_SCALE_VAL_MSB  12
`define MMT_SCALE_IDX_LSB  16
`define MMT_SCALE_IDX_MSB  19

// accepted scale range, hundredths: 1.00 and 50.00
`define MMT_SCALE_MIN      13'h0064
`define MMT_SCALE_MAX      13'h1388
`define MMT_PCT_SCALE      32'h0000_0064

// factory table, entry 15 first down to entry 0, hundredths
`define MMT_SCALE_FACTORY {13'h0064, 13'h006f, 13'h007d, 13'h008f, \
	13'h00a7, 13'h00c8, 13'h00de, 13'h00fa, 13'h011e, 13'h014d, \
	13'h0190, 13'h01f4, 13'h029b, 13'h03e8, 13'h0596, 13'h07d0}

// interrupt status bit positions
`define MMT_IRQ_ENTER      0
`define MMT_IRQ_TIMEOUT    1
`define MMT_IRQ_REJECT     2
`define MMT_IRQ_FAULT      3

// reset values, and the hsize code for a whole-word transfer
`define MMT_IRQ_MASK_RST   4'h0
`define MMT_HSIZE_WORD     3'h2

// timing: clock rate and the manual mode timeout in seconds
`define MMT_CLK_HZ         40000000
`define MMT_TIMEOUT_S      10

`endif

// ==== hw/mmt_pkg.sv ====
`default_nettype none

package mmt_pkg;

	// one set of drive control signals, from the fieldbus or the tool
	typedef struct packed {
		logic       ctrl_enable;             // reset / controller enable
		logic       clockwise_run;
		logic       counterclockwise_run;
		logic       primary_setpoint_source;
		logic [3:0] scale_select_bits;
	} mmt_ctrl_s;

	// process values from the power stage
	typedef struct packed {
		logic [15:0] output_current;
		logic [15:0] speed;
	} mmt_proc_s;

	// scaling factor in hundredths
	typedef logic [12:0] mmt_scale_t;

	// operating state reported to the tool
	typedef enum logic [1:0] {
		MMT_OP_INHIBIT = 2'b00,
		MMT_OP_STOP    = 2'b01,
		MMT_OP_RUN     = 2'b10,
		MMT_OP_FAULT   = 2'b11
	} mmt_op_e;

endpackage

`default_nettype wire

// ==== hw/mmt_scale_table.sv ====
`default_nettype none
`include "mmt_cfg.svh"

module mmt_scale_table
	import mmt_pkg::*;
(
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       wr_en,
	input  wire logic [3:0] wr_idx,
	input  wire mmt_scale_t wr_val,
	input  wire logic       restore,
	input  wire logic [3:0] rd_idx,
	output mmt_scale_t      rd_val
);

	typedef struct packed {
		logic [15:0][12:0] entry;    // sixteen factors, flip-flops
	} mmt_tbl_state_s;

	mmt_tbl_state_s s;               // registered table
	mmt_tbl_state_s next_s;          // next table contents

	// restore outranks a download landing in the same cycle
	always_comb begin
		next_s = s;
		if (restore) begin
			next_s.entry = `MMT_SCALE_FACTORY;
		end else if (wr_en) begin
			next_s.entry[wr_idx] = wr_val;
		end
	end

	// factory contents at reset as well
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s.entry <= `MMT_SCALE_FACTORY;
		end else begin
			s <= next_s;
		end
	end

	// read is combinational so the setpoint path sees a new code at once
	assign rd_val = s.entry[rd_idx];

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	chk_restore_all: assert property (restore |=>
		s.entry == $past(`MMT_SCALE_FACTORY))
		else $error("restore did not reload every entry");

	chk_factory_ends: assert property (restore |=>
		s.entry[0] == 13'h07d0 && s.entry[15] == 13'h0064)
		else $error("factory ends are not 20.00 and 1.00");

endmodule

`default_nettype wire

// ==== hw/mmt_manual_takeover.sv ====
// Design decisions made here: register access over AHB-Lite and the placing of the registers.
`default_nettype none
`include "mmt_cfg.svh"
// Contract
// - downloads accepted only from 1.00 to 50.00
// - sixteen factors, factory 20 down to 1
// - restore command reloads all factory factors
// - entering manual clears controls, raises flag
// - power cycle restarts under fieldbus control
// - manual controls apply only on commit
// - enable needs controller enable plus direction
// - primary source setpoint includes selected factor
// - timeout monitor runs while tool sends no writes
// - after 10 s leave manual mode
// - fieldbus controls apply at once on timeout
// - fault clears only on enable rising edge
// - setpoint, factor, ramp reported read only
// - status flags, state, process values reported

module mmt_manual_takeover
	import mmt_pkg::*;
#(
	parameter int TIMEOUT_CYCLES = `MMT_TIMEOUT_S * `MMT_CLK_HZ
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire mmt_ctrl_s   asi_ctrl,
	input  wire logic        fault_in,
	input  wire logic [15:0] setpoint_base,
	input  wire logic [15:0] ramp_time_pot,
	input  wire mmt_proc_s   process_in,
	output mmt_ctrl_s        drive_ctrl,
	output logic             drive_enable,
	output logic             fault_reset,
	output logic      [15:0] speed_setpoint,
	output mmt_op_e          op_state,
	output logic             manual_active,
	output logic             irq
);

	typedef struct packed {
		logic        manual;      // tool holds control
		mmt_ctrl_s   staged;      // bits toggled by the tool
		mmt_ctrl_s   applied;     // committed manual combination
		mmt_ctrl_s   drive;       // controls the drive really sees
		logic        prev_en;     // enable one cycle back
		logic        fault;       // latched malfunction
		logic        fault_rst;   // one-cycle fault reset pulse
		logic        drv_en;      // output stage enabled
		mmt_op_e     op;          // operating state
		logic [15:0] setpoint;    // effective speed setpoint
		logic [31:0] tmo;         // silence counter in manual mode
		logic [3:0]  irq_stat;    // sticky events
		logic [3:0]  irq_mask;    // event enables
		logic        irq;         // interrupt line
		logic        tbl_wr;      // table write strobe
		logic        tbl_restore; // table restore strobe
		logic [3:0]  tbl_idx;     // last accepted index
		mmt_scale_t  tbl_val;     // last accepted value
		logic        dph_valid;   // a data phase is running
		logic        dph_write;   // it is a write
		logic        dph_word;    // it is a whole word
		logic [7:0]  dph_addr;    // its register offset
		logic [31:0] rdata;       // read data for the bus
		logic        ready_out;   // always ready, no wait states
	} mmt_top_state_s;

	mmt_top_state_s s;        // registered state
	mmt_top_state_s next_s;   // next state
	mmt_scale_t     sel_val;  // factor at the driven code

	// register offset match, used for every write decode
	function automatic logic at(input logic [7:0] a, input logic [7:0] o);
		return a == o;
	endfunction

	// speed setpoint, divided by the factor when source one is chosen
	function automatic logic [15:0] calc_setpoint(
		input logic [15:0] base,
		input mmt_scale_t  f,
		input logic        prim
	);
		logic [31:0] q;
		q = ({16'h0, base} * `MMT_PCT_SCALE) / {19'h0, f};
		return prim ? q[15:0] : base;
	endfunction

	// factor storage lives in its own small module
	mmt_scale_table u_table (
		.hclk    (hclk),
		.hresetn (hresetn),
		.wr_en   (s.tbl_wr),
		.wr_idx  (s.tbl_idx),
		.wr_val  (s.tbl_val),
		.restore (s.tbl_restore),
		.rd_idx  (s.drive.scale_select_bits),
		.rd_val  (sel_val)
	);

	// whole next-state function: bus, manual mode, fault, interrupts
	always_comb begin
		logic       wr;       // write data phase in progress
		logic       ap;       // address phase taken
		logic       enter;    // tool asks for control
		logic       leave;    // control returns to the fieldbus
		logic       expire;   // silence reached the limit
		logic       commit;   // staged bits go live
		logic       edge_en;  // enable has just risen
		logic       in_rng;   // download within limits
		logic [3:0] ev;       // events this cycle
		logic [3:0] clr;      // write-one-to-clear bits
		mmt_scale_t wval;     // downloaded factor
		next_s  = s;
		wr      = s.dph_valid & s.dph_write & s.dph_word;
		ap      = hsel & htrans[1] & hready;
		wval    = hwdata[`MMT_SCALE_VAL_MSB:0];
		enter   = wr & at(s.dph_addr, `MMT_OFS_CTRL)
			& hwdata[`MMT_CTRL_ENTER] & ~s.manual;
		// a whole-word tool write in this cycle holds the timeout off; reads do not
		expire  = s.manual & ~wr
			& (s.tmo == 32'(TIMEOUT_CYCLES - 1));
		leave   = s.manual & ((wr & at(s.dph_addr, `MMT_OFS_CTRL)
			& hwdata[`MMT_CTRL_EXIT]) | expire);
		commit  = s.manual & wr & at(s.dph_addr, `MMT_OFS_CTRL)
			& hwdata[`MMT_CTRL_COMMIT];
		edge_en = s.drive.ctrl_enable & ~s.prev_en;
		in_rng  = (wval >= `MMT_SCALE_MIN) && (wval <= `MMT_SCALE_MAX);
		ev      = 4'h0;
		clr     = 4'h0;

		// manual mode entry, exit and silence monitor
		if (enter) begin
			next_s.manual  = 1'b1;
			next_s.staged  = '0;
			next_s.applied = '0;
			next_s.tmo     = 32'h0;
			ev[`MMT_IRQ_ENTER] = 1'b1;
		end else if (leave) begin
			next_s.manual = 1'b0;
			next_s.tmo    = 32'h0;
			ev[`MMT_IRQ_TIMEOUT] = expire;
		end else if (s.manual) begin
			if (wr) begin
				next_s.tmo = 32'h0;
			end else begin
				next_s.tmo = s.tmo + 32'h1;
			end
			if (wr & at(s.dph_addr, `MMT_OFS_MANUAL)) begin
				next_s.staged = mmt_ctrl_s'(hwdata[7:0]);
			end
			if (commit) begin
				next_s.applied = s.staged;
			end
		end

		// factor download and restore, out-of-range values refused
		next_s.tbl_wr      = 1'b0;
		next_s.tbl_restore = wr & at(s.dph_addr, `MMT_OFS_CTRL)
			& hwdata[`MMT_CTRL_RESTORE];
		if (wr & at(s.dph_addr, `MMT_OFS_SCALE)) begin
			if (in_rng) begin
				next_s.tbl_wr  = 1'b1;
				next_s.tbl_idx =
					hwdata[`MMT_SCALE_IDX_MSB:`MMT_SCALE_IDX_LSB];
				next_s.tbl_val = wval;
			end else begin
				ev[`MMT_IRQ_REJECT] = 1'b1;
			end
		end

		// control source: the fieldbus takes over in the leaving cycle
		next_s.drive   = next_s.manual ? next_s.applied : asi_ctrl;
		next_s.prev_en = s.drive.ctrl_enable;

		// fault latch, set wins over the enable edge
		next_s.fault_rst = edge_en;
		next_s.fault     = fault_in | (s.fault & ~edge_en);
		ev[`MMT_IRQ_FAULT] = fault_in & ~s.fault;

		// enable needs controller enable and a direction
		next_s.drv_en = next_s.drive.ctrl_enable & ~next_s.fault
			& (next_s.drive.clockwise_run
			| next_s.drive.counterclockwise_run);
		if (next_s.fault) begin
			next_s.op = MMT_OP_FAULT;
		end else if (!next_s.drive.ctrl_enable) begin
			next_s.op = MMT_OP_INHIBIT;
		end else if (next_s.drv_en) begin
			next_s.op = MMT_OP_RUN;
		end else begin
			next_s.op = MMT_OP_STOP;
		end

		// setpoint lags the control code by one cycle
		next_s.setpoint = calc_setpoint(setpoint_base, sel_val,
			s.drive.primary_setpoint_source);

		// sticky interrupts: a new event beats its own clear
		if (wr & at(s.dph_addr, `MMT_OFS_IRQ_STAT)) begin
			clr = hwdata[3:0];
		end
		if (wr & at(s.dph_addr, `MMT_OFS_IRQ_MASK)) begin
			next_s.irq_mask = hwdata[3:0];
		end
		next_s.irq_stat = (s.irq_stat & ~clr) | ev;
		next_s.irq      = |(next_s.irq_stat & next_s.irq_mask);

		// bus slave: capture the address phase, answer with no wait
		next_s.ready_out = 1'b1;
		next_s.dph_valid = ap;
		next_s.dph_write = hwrite;
		next_s.dph_word  = hsize == `MMT_HSIZE_WORD;
		next_s.dph_addr  = haddr[7:0];
		if (ap & ~hwrite) begin
			// the status, setpoint and process views below are read only to the tool
			case (haddr[7:0])
				`MMT_OFS_CTRL: begin
					next_s.rdata = {31'h0, s.manual};
				end
				`MMT_OFS_MANUAL: begin
					next_s.rdata = {16'h0, s.drive, s.staged};
				end
				`MMT_OFS_SCALE: begin
					next_s.rdata = {12'h0, s.tbl_idx, 3'h0, s.tbl_val};
				end
				`MMT_OFS_STATUS: begin
					next_s.rdata = {3'h0, sel_val,
						4'h0, s.drive.scale_select_bits,
						2'h0, s.op, s.manual, s.fault,
						s.drv_en, ~s.fault};
				end
				`MMT_OFS_SETPOINT: begin
					next_s.rdata = {ramp_time_pot, s.setpoint};
				end
				`MMT_OFS_PROCESS: begin
					next_s.rdata = {process_in.speed,
						process_in.output_current};
				end
				`MMT_OFS_IRQ_STAT: begin
					next_s.rdata = {28'h0, s.irq_stat};
				end
				`MMT_OFS_IRQ_MASK: begin
					next_s.rdata = {28'h0, s.irq_mask};
				end
				default: begin
					next_s.rdata = 32'h0; // unmapped reads zero
				end
			endcase
		end
	end

	// a supply cycle is a reset: fieldbus control, no manual mode
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s           <= '0;
			s.irq_mask  <= `MMT_IRQ_MASK_RST;
			s.ready_out <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// all outputs but hresp come straight from state flops; hresp is tied low
	assign hrdata         = s.rdata;
	assign hreadyout      = s.ready_out;
	assign hresp          = 1'b0;
	assign drive_ctrl     = s.drive;
	assign drive_enable   = s.drv_en;
	assign fault_reset    = s.fault_rst;
	assign speed_setpoint = s.setpoint;
	assign op_state       = s.op;
	assign manual_active  = s.manual;
	assign irq            = s.irq;

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	chk_scale_range: assert property (s.tbl_wr |->
		s.tbl_val >= 13'h0064 && s.tbl_val <= 13'h1388)
		else $error("out of range factor reached the table");

	chk_enter_defaults: assert property ($rose(s.manual) |->
		s.drive == '0 && !s.drv_en && s.irq_stat[0])
		else $error("manual entry did not clear the controls");

	chk_reset_bus_ctrl: assert property ($rose(hresetn) |->
		!s.manual)
		else $error("manual mode survived a reset");

	chk_commit_only: assert property ((s.manual && next_s.manual
		&& next_s.applied == s.applied) |=> $stable(s.drive))
		else $error("manual controls changed without commit");

	chk_enable_cond: assert property (drive_enable |->
		drive_ctrl.ctrl_enable && (drive_ctrl.clockwise_run
		|| drive_ctrl.counterclockwise_run) && op_state == MMT_OP_RUN)
		else $error("drive enabled without enable and direction");

	chk_unity_factor: assert property ((s.drive.primary_setpoint_source
		&& sel_val == 13'h0064) |=>
		speed_setpoint == $past(setpoint_base))
		else $error("factor 1.00 changed the setpoint");

	chk_idle_counter: assert property (!s.manual |->
		s.tmo == 32'h0)
		else $error("silence counter ran outside manual mode");

	chk_timeout_exit: assert property ((s.manual
		&& !(s.dph_valid && s.dph_write && s.dph_word)
		&& s.tmo == 32'(TIMEOUT_CYCLES - 1))
		|=> !manual_active && s.irq_stat[1])
		else $error("timeout did not leave manual mode");

	chk_fieldbus_take: assert property ((s.manual && !next_s.manual)
		|=> drive_ctrl == $past(asi_ctrl))
		else $error("fieldbus controls not applied at once");

	chk_fault_edge: assert property (fault_reset |->
		$past(drive_ctrl.ctrl_enable) && !$past(drive_ctrl.ctrl_enable, 2))
		else $error("fault reset without an enable edge");

	chk_frame_restart: assert property ((s.manual && next_s.manual
		&& s.dph_valid && s.dph_write && s.dph_word) |=> s.tmo == 32'h0)
		else $error("tool frame did not restart the timeout");

	cov_enter: cover property ($rose(manual_active));
	cov_timeout: cover property ($fell(manual_active) && s.irq_stat[1]);
	cov_reject: cover property ($rose(s.irq_stat[2]));
	cov_fault_clear: cover property (s.fault ##1 fault_reset);

endmodule

`default_nettype wire

// ==== dv/mmt_tool_model.sv ====
`default_nettype none

// service tool side: a single ahb master issuing whole-word transfers
module mmt_tool_model (
	input  wire logic        hclk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic      [31:0] haddr,
	output logic      [1:0]  htrans,
	output logic             hwrite,
	output logic      [2:0]  hsize,
	output logic      [31:0] hwdata
);
	timeunit 1ns;
	timeprecision 100ps;

	// bus idle at time zero
	initial begin
		hsel   = 1'b0;
		haddr  = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize  = 3'h2;
		hwdata = 32'h0;
	end

	// one transfer, entered just after a rising edge; the tool only
	// learns results by reading, never by a pushed message
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		hsize  <= 3'h2;
		// address phase held until the slave samples it
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		// a read carries no data: drive a pattern, not stale data
		hwdata <= w ? d : ~hwdata;
		do @(posedge hclk); while (hready !== 1'b1);
		r = hrdata;
	endtask
endmodule

`default_nettype wire

// ==== dv/tb.sv ====
`default_nettype none
`include "mmt_cfg.svh"

module tb
	import mmt_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int TO = 64; // shortened manual timeout

	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	mmt_ctrl_s   asi_ctrl;      // fieldbus master controls
	logic        fault_in;
	logic [15:0] setpoint_base;
	logic [15:0] ramp_time_pot;
	mmt_proc_s   process_in;
	mmt_ctrl_s   drive_ctrl;
	logic        drive_enable;
	logic        fault_reset;
	logic [15:0] speed_setpoint;
	mmt_op_e     op_state;
	logic        manual_active;
	logic        irq;
	logic [31:0] rv;            // last word read
	int          fails;
	int          comparisons;
	int          n_frst;        // fault reset pulses seen
	// factory factors in hundredths, code 0 first
	logic [12:0] fac [16] = '{13'h07d0, 13'h0596, 13'h03e8, 13'h029b,
		13'h01f4, 13'h0190, 13'h014d, 13'h011e, 13'h00fa, 13'h00de,
		13'h00c8, 13'h00a7, 13'h008f, 13'h007d, 13'h006f, 13'h0064};

	mmt_manual_takeover #(.TIMEOUT_CYCLES(TO)) u_mmt_manual_takeover (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .asi_ctrl(asi_ctrl),
		.fault_in(fault_in), .setpoint_base(setpoint_base),
		.ramp_time_pot(ramp_time_pot), .process_in(process_in),
		.drive_ctrl(drive_ctrl), .drive_enable(drive_enable),
		.fault_reset(fault_reset), .speed_setpoint(speed_setpoint),
		.op_state(op_state), .manual_active(manual_active), .irq(irq));

	mmt_tool_model u_mmt_tool_model (
		.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata));

	// 40 mhz clock
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end

	// pulses are one cycle wide, so count them rather than poll
	always @(posedge hclk) begin
		if (fault_reset === 1'b1) n_frst <= n_frst + 1;
	end

	task automatic chk(input string n, input logic [31:0] s, e);
		comparisons++;
		if (s !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic close_out();
		$display("fails %0d comparisons %0d", fails, comparisons);
		if (fails == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_mmt_tool_model.xfer(1'b1, a, d, rv);
	endtask

	task automatic rd(input logic [7:0] a);
		u_mmt_tool_model.xfer(1'b0, a, 32'h0, rv);
	endtask

	// lets a write's effects and the setpoint lag land
	task automatic settle();
		repeat (3) @(posedge hclk);
	endtask

	task automatic commit(input logic [7:0] c);
		wr(`MMT_OFS_MANUAL, 32'(c));
		wr(`MMT_OFS_CTRL, 32'h8);
		settle();
	endtask

	task automatic sel(input logic [7:0] c, input logic [12:0] e);
		commit(c);
		rd(`MMT_OFS_STATUS);
		chk("factor", 32'(rv[28:16]), 32'(e));
	endtask

	task automatic t_reset();
		chk("manual idle", 32'(manual_active), 32'h0);
		chk("follows bus", 32'(drive_ctrl), 32'h85);
		chk("no direction", 32'(drive_enable), 32'h0);
		rd(`MMT_OFS_IRQ_MASK);
		chk("mask reset", rv, 32'h0);
		wr(8'h40, 32'hffff_ffff);
		rd(8'h40);
		chk("unmapped", rv, 32'h0);
		chk("okay", 32'(hresp), 32'h0);
		chk("ready", 32'(hreadyout), 32'h1);
	endtask

	task automatic t_enter();
		wr(`MMT_OFS_CTRL, 32'h1);
		settle();
		chk("manual on", 32'(manual_active), 32'h1);
		chk("defaults", 32'(drive_ctrl), 32'h0);
		rd(`MMT_OFS_STATUS);
		chk("manual flag", 32'(rv[3]), 32'h1);
		rd(`MMT_OFS_IRQ_STAT);
		chk("enter event", 32'(rv[0]), 32'h1);
		chk("masked", 32'(irq), 32'h0);
		wr(`MMT_OFS_IRQ_STAT, 32'h1);
	endtask

	// every code, each staged and held before its commit
	task automatic t_table();
		logic [7:0] c;
		for (int i = 0; i < 16; i++) begin
			c = 8'h10 | 8'(i);
			wr(`MMT_OFS_MANUAL, 32'(c));
			settle();
			chk("held", 32'(drive_ctrl), 32'(i == 0 ? 8'h0 : c - 8'h1));
			wr(`MMT_OFS_CTRL, 32'h8);
			settle();
			chk("applied", 32'(drive_ctrl), 32'(c));
			rd(`MMT_OFS_STATUS);
			chk("factor", 32'(rv[28:16]), 32'(fac[i]));
			chk("scaled", 32'(speed_setpoint), 32'h186a0 / 32'(fac[i]));
		end
		commit(8'h03);
		chk("plain", 32'(speed_setpoint), 32'h03e8);
		wr(`MMT_OFS_SETPOINT, 32'h0);
		rd(`MMT_OFS_SETPOINT);
		chk("read only", rv, 32'h01f4_03e8);
	endtask

	// range edges, reject interrupt, then factory restore
	task automatic t_download();
		wr(`MMT_OFS_IRQ_MASK, 32'h4);
		wr(`MMT_OFS_SCALE, 32'h0000_0063);
		settle();
		chk("low reject", 32'(irq), 32'h1);
		wr(`MMT_OFS_IRQ_STAT, 32'h4);
		wr(`MMT_OFS_SCALE, 32'h0001_1389);
		settle();
		chk("high reject", 32'(irq), 32'h1);
		wr(`MMT_OFS_IRQ_STAT, 32'h4);
		wr(`MMT_OFS_SCALE, 32'h0000_1388);
		wr(`MMT_OFS_SCALE, 32'h0001_0064);
		settle();
		chk("accept", 32'(irq), 32'h0);
		sel(8'h00, 13'h1388);
		sel(8'h01, 13'h0064);
		wr(`MMT_OFS_CTRL, 32'h4);
		sel(8'h00, 13'h07d0);
		sel(8'h01, 13'h0596);
	endtask

	task automatic t_enable();
		logic [7:0] cs [5] = '{8'hc0, 8'ha0, 8'h80, 8'h40, 8'h60};
		logic [1:0] os [5] = '{2'h2, 2'h2, 2'h1, 2'h0, 2'h0};
		for (int i = 0; i < 5; i++) begin
			commit(cs[i]);
			chk("enable", 32'(drive_enable), 32'(i < 2));
			chk("state", 32'(op_state), 32'(os[i]));
			rd(`MMT_OFS_STATUS);
			chk("stage flag", 32'(rv[1]), 32'(i < 2));
		end
	endtask

	task automatic t_fault();
		int n0;
		commit(8'h80);
		fault_in <= 1'b1;
		settle();
		fault_in <= 1'b0;
		settle();
		chk("fault held", 32'(op_state), 32'(MMT_OP_FAULT));
		rd(`MMT_OFS_STATUS);
		chk("fault flags", 32'({rv[2], rv[0]}), 32'h2);
		n0 = n_frst;
		// the tool must drop and raise enable to make the edge
		commit(8'h00);
		commit(8'h80);
		chk("reset pulse", 32'(n_frst - n0), 32'h1);
		chk("cleared", 32'(op_state), 32'(MMT_OP_STOP));
	endtask

	task automatic t_timeout();
		asi_ctrl <= 8'h15;
		wr(`MMT_OFS_IRQ_MASK, 32'h2);
		repeat (TO - 8) @(posedge hclk);
		wr(8'h40, 32'h0);
		repeat (TO - 4) @(posedge hclk);
		chk("kept", 32'(manual_active), 32'h1);
		repeat (8) @(posedge hclk);
		chk("expired", 32'(manual_active), 32'h0);
		chk("fieldbus", 32'(drive_ctrl), 32'h15);
		chk("no start", 32'(drive_enable), 32'h0);
		chk("timeout irq", 32'(irq), 32'h1);
		wr(`MMT_OFS_IRQ_STAT, 32'h2);
		settle();
		chk("irq clear", 32'(irq), 32'h0);
	endtask

	// supply cycle while in manual mode
	task automatic t_power();
		wr(`MMT_OFS_CTRL, 32'h1);
		settle();
		chk("entered", 32'(manual_active), 32'h1);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		settle();
		chk("after cycle", 32'(manual_active), 32'h0);
		chk("fieldbus ctrl", 32'(drive_ctrl), 32'h15);
		rd(`MMT_OFS_PROCESS);
		chk("process", rv, 32'h0056_1234);
		// exit bit hands control back without a timeout event
		wr(`MMT_OFS_CTRL, 32'h1);
		wr(`MMT_OFS_CTRL, 32'h2);
		settle();
		chk("exit", 32'(manual_active), 32'h0);
		chk("exit ctrl", 32'(drive_ctrl), 32'h15);
		rd(`MMT_OFS_IRQ_STAT);
		chk("exit events", rv, 32'h1);
	endtask

	initial begin
		fails = 0;
		comparisons = 0;
		n_frst = 0;
		hresetn = 1'b0;
		asi_ctrl = 8'h85;
		fault_in = 1'b0;
		setpoint_base = 16'h03e8;
		ramp_time_pot = 16'h01f4;
		process_in = 32'h1234_0056;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		settle();
		t_reset();
		t_enter();
		t_table();
		t_download();
		t_enable();
		t_fault();
		t_timeout();
		t_power();
		close_out();
	end

	// run needs about 520 cycles; a hang ends here
	initial begin
		repeat (20000) @(posedge hclk);
		fails++;
		close_out();
	end
endmodule

`default_nettype wire
